/* File: include/intprio_pkg.sv */
package intprio_pkg;

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int NUM_SRC     = 16;
  localparam int NUM_TRAP    = 4;
  localparam int PRIO_W      = 3;
  localparam int LEVEL_W     = 4;
  localparam int VEC_W       = 7;
  localparam int ADDR_W      = 4;
  localparam int DATA_W      = 16;
  localparam int IDX_W       = 4;
  localparam int TRAP_IDX_W  = 2;
  localparam int STACK_DEPTH = 8;
  localparam int DEPTH_W     = 4;
  localparam int DIS_W       = 14;

  // ------------------------------------------------------------
  // Register word addresses
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_PRIO_ENC1_PWM1    = 4'h0;
  localparam logic [ADDR_W-1:0] REG_PRIO_FLT1_RTC_DMA = 4'h1;
  localparam logic [ADDR_W-1:0] REG_PRIO_CRC_SERIAL   = 4'h2;
  localparam logic [ADDR_W-1:0] REG_PRIO_CANTX_DMA    = 4'h3;
  localparam logic [ADDR_W-1:0] REG_PRIO_ENC2_FLT_PWM = 4'h4;
  localparam logic [ADDR_W-1:0] REG_PRIO_DAC          = 4'h5;
  localparam logic [ADDR_W-1:0] REG_LEVEL_VECTOR      = 4'h6;
  localparam logic [ADDR_W-1:0] REG_INT_CONTROL_ONE   = 4'h7;
  localparam logic [ADDR_W-1:0] REG_FLAG_STATUS       = 4'h8;
  localparam logic [ADDR_W-1:0] REG_ENABLE_CTRL       = 4'h9;
  localparam logic [ADDR_W-1:0] REG_CPU_LEVEL         = 4'ha;

  // ------------------------------------------------------------
  // Field layout and reset values
  // ------------------------------------------------------------
  localparam int NEST_DIS_BIT   = 15;
  localparam int STAT_LEVEL_LSB = 8;
  localparam int STAT_VEC_LSB   = 0;

  localparam logic [PRIO_W-1:0]  PRIO_RESET     = 3'h4;
  localparam logic [PRIO_W-1:0]  PRIO_OFF       = 3'h0;
  localparam logic [PRIO_W-1:0]  PRIO_TOP       = 3'h7;
  localparam logic [LEVEL_W-1:0] TRAP_LEVEL_MIN = 4'h8;
  localparam logic [VEC_W-1:0]   USER_VEC_BASE  = 7'h10;

  // Sources in tie order: encoder1, pwm1, fault1, calendar, dma5, checksum,
  // serial2 err, serial1 err, can tx, dma7, dma6, encoder2, fault2, pwm2,
  // dac left, dac right
  localparam logic [NUM_SRC-1:0][ADDR_W-1:0] SRC_REG = {
    4'h5, 4'h5, 4'h4, 4'h4, 4'h4, 4'h3, 4'h3, 4'h3,
    4'h2, 4'h2, 4'h2, 4'h1, 4'h1, 4'h1, 4'h0, 4'h0};
  localparam logic [NUM_SRC-1:0][3:0] SRC_LSB = {
    4'h8, 4'hc, 4'h4, 4'h8, 4'hc, 4'h0, 4'h4, 4'h8,
    4'h4, 4'h8, 4'hc, 4'h4, 4'h8, 4'hc, 4'h4, 4'h8};
  localparam int SRC_CAN_TX    = 8;
  localparam int SRC_DAC_LEFT  = 14;
  localparam int SRC_DAC_RIGHT = 15;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic                    req;
    logic                    is_user;
    logic [VEC_W-1:0]        vec;
    logic [LEVEL_W-1:0]      level;
    logic [IDX_W-1:0]        idx;
  } irq_req_t;

  typedef struct packed {
    logic [NUM_SRC-1:0][PRIO_W-1:0]       prio;
    logic [NUM_SRC-1:0]                   flags;
    logic [NUM_SRC-1:0]                   en;
    logic [NUM_TRAP-1:0]                  trap;
    logic                                 nest_dis;
    logic [LEVEL_W-1:0]                   cpu_level;
    logic [STACK_DEPTH-1:0][LEVEL_W-1:0]  stack;
    logic [DEPTH_W-1:0]                   depth;
    logic [DIS_W-1:0]                     dis_cnt;
    logic                                 dis_act;
    irq_req_t                             irq;
    logic [DATA_W-1:0]                    rdata;
  } ctl_state_t;

  localparam ctl_state_t STATE_RESET = '{prio: {NUM_SRC{PRIO_RESET}}, default: '0};

endpackage

/* File: hw/prio_picker.sv */
`timescale 1ns/1ps
module prio_picker #(
  parameter int N  = 16,
  parameter int PW = 3,
  parameter int IW = 4
) (
  input  wire logic [N-1:0]         req_in,
  input  wire logic [N-1:0][PW-1:0] prio_in,
  output logic                      found_out,
  output logic [IW-1:0]             idx_out,
  output logic [PW-1:0]             prio_out
);

  logic [N:0]         found_c;
  logic [N:0][PW-1:0] prio_c;
  logic [N:0][IW-1:0] idx_c;

  assign found_c[0] = 1'b0;
  assign prio_c[0]  = '0;
  assign idx_c[0]   = '0;

  // ------------------------------------------------------------
  // Chain: strict compare keeps the lowest index on a tie
  // ------------------------------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_stage
    logic take;
    assign take         = req_in[i] && (!found_c[i] || (prio_in[i] > prio_c[i]));
    assign found_c[i+1] = found_c[i] | req_in[i];
    assign prio_c[i+1]  = take ? prio_in[i] : prio_c[i];
    assign idx_c[i+1]   = take ? IW'(i) : idx_c[i];
  end

  assign found_out = found_c[N];
  assign idx_out   = idx_c[N];
  assign prio_out  = prio_c[N];

endmodule

/* File: hw/interrupt_priority_control.sv */
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
// Function
// - Field value gives priority level one to seven
// - Zero priority field never produces a request
// - Priority fields reset to level four
// - Status bits 11-8 show new CPU level
// - Status bits 6-0 show the pending vector as driven on INT_VECTOR_OUT
// - Fields sit in the four three-bit slots
// - Unused bits read zero, writes ignored
// - Nesting disable blocks user-source preemption during service
// - Source requests only while enabled
// - Flag still set after return retriggers
// - Return restores the stacked CPU level
// - Trap repeats until its flag is cleared
// - CPU level seven masks all user sources
// - Traps ignore disables but must be above CPU level
// - Timed disable blocks levels one to six
// - Level seven passes during timed disable
// - Absent CAN or DAC sources stay inactive
// - Equal nonzero priorities still work
module interrupt_priority_control #(
  parameter bit HAS_CAN = 1'b1,
  parameter bit HAS_DAC = 1'b1
) (
  input  wire logic                                CLK_SYS_IN,
  input  wire logic                                RESET_N_IN,
  input  wire logic [intprio_pkg::ADDR_W-1:0]      ADDR_IN,
  input  wire logic [intprio_pkg::DATA_W-1:0]      WDATA_IN,
  input  wire logic                                WR_IN,
  input  wire logic                                RD_IN,
  output logic      [intprio_pkg::DATA_W-1:0]      RDATA_OUT,
  input  wire logic [intprio_pkg::NUM_SRC-1:0]     SRC_EVENT_IN,
  input  wire logic [intprio_pkg::NUM_TRAP-1:0]    TRAP_EVENT_IN,
  input  wire logic                                INT_ACK_IN,
  input  wire logic                                INT_RETURN_IN,
  input  wire logic                                DISABLE_START_IN,
  input  wire logic [intprio_pkg::DIS_W-1:0]       DISABLE_CYCLES_IN,
  output logic                                     INT_REQ_OUT,
  output logic      [intprio_pkg::VEC_W-1:0]       INT_VECTOR_OUT,
  output logic      [intprio_pkg::LEVEL_W-1:0]     INT_LEVEL_OUT,
  output logic      [intprio_pkg::LEVEL_W-1:0]     CPU_LEVEL_OUT,
  output logic                                     DISABLE_ACTIVE_OUT
);

  intprio_pkg::ctl_state_t s_reg;
  intprio_pkg::ctl_state_t s_next;

  logic [intprio_pkg::NUM_SRC-1:0]    present;
  logic [intprio_pkg::NUM_SRC-1:0]    eligible;
  logic                               pick_found;
  logic [intprio_pkg::IDX_W-1:0]      pick_idx;
  logic [intprio_pkg::PRIO_W-1:0]     pick_prio;
  logic [intprio_pkg::LEVEL_W-1:0]    pick_level;
  logic                               user_ok;
  logic                               trap_any;
  logic [intprio_pkg::TRAP_IDX_W-1:0] trap_idx;
  logic [intprio_pkg::LEVEL_W-1:0]    trap_level;
  logic                               trap_ok;
  logic                               taken;
  logic [intprio_pkg::LEVEL_W-1:0]    stack_top;
  logic [intprio_pkg::DATA_W-1:0]     rd_word;

  // ------------------------------------------------------------
  // Source qualification
  // ------------------------------------------------------------
  always_comb begin
    present = '1;
    present[intprio_pkg::SRC_CAN_TX]    = HAS_CAN;
    present[intprio_pkg::SRC_DAC_LEFT]  = HAS_DAC;
    present[intprio_pkg::SRC_DAC_RIGHT] = HAS_DAC;
  end

  for (genvar i = 0; i < intprio_pkg::NUM_SRC; i++) begin : g_elig
    // Zero field means disabled; flag and enable alone are not enough
    assign eligible[i] = s_reg.flags[i] & s_reg.en[i] & present[i]
                         & (s_reg.prio[i] != intprio_pkg::PRIO_OFF);
  end

  prio_picker #(
    .N  (intprio_pkg::NUM_SRC),
    .PW (intprio_pkg::PRIO_W),
    .IW (intprio_pkg::IDX_W)
  ) u_picker (
    .req_in    (eligible),
    .prio_in   (s_reg.prio),
    .found_out (pick_found),
    .idx_out   (pick_idx),
    .prio_out  (pick_prio)
  );

  // ------------------------------------------------------------
  // Acceptance
  // ------------------------------------------------------------
  always_comb begin
    pick_level = {1'b0, pick_prio};
    // Equal levels fall to the index tie break, so a flat scheme still works
    user_ok = pick_found && (pick_level > s_reg.cpu_level)
              && !((s_reg.dis_cnt != '0) && (pick_prio != intprio_pkg::PRIO_TOP))
              && !(s_reg.nest_dis && (s_reg.depth != '0));
    trap_any = |s_reg.trap;
    trap_idx = '0;
    for (int t = 0; t < intprio_pkg::NUM_TRAP; t++) begin
      if (s_reg.trap[t]) begin
        trap_idx = intprio_pkg::TRAP_IDX_W'(t);
      end
    end
    trap_level = intprio_pkg::TRAP_LEVEL_MIN + intprio_pkg::LEVEL_W'(trap_idx);
    // Only a higher trap can interrupt a trap; no disable reaches here
    trap_ok   = trap_any && (trap_level > s_reg.cpu_level);
    taken     = INT_ACK_IN && s_reg.irq.req;
    stack_top = (s_reg.depth != '0) ? s_reg.stack[3'(s_reg.depth - 4'h1)] : '0;
  end

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  always_comb begin
    rd_word = '0;
    for (int i = 0; i < intprio_pkg::NUM_SRC; i++) begin
      if (ADDR_IN == intprio_pkg::SRC_REG[i]) begin
        rd_word[intprio_pkg::SRC_LSB[i] +: intprio_pkg::PRIO_W] = s_reg.prio[i];
      end
    end
    case (ADDR_IN)
      intprio_pkg::REG_LEVEL_VECTOR: begin
        rd_word[intprio_pkg::STAT_LEVEL_LSB +: intprio_pkg::LEVEL_W] = s_reg.irq.level;
        rd_word[intprio_pkg::STAT_VEC_LSB +: intprio_pkg::VEC_W]     = s_reg.irq.vec;
      end
      intprio_pkg::REG_INT_CONTROL_ONE: begin
        rd_word[intprio_pkg::NEST_DIS_BIT]      = s_reg.nest_dis;
        rd_word[intprio_pkg::NUM_TRAP-1:0]      = s_reg.trap;
      end
      intprio_pkg::REG_FLAG_STATUS: rd_word = s_reg.flags;
      intprio_pkg::REG_ENABLE_CTRL: rd_word = s_reg.en;
      intprio_pkg::REG_CPU_LEVEL:   rd_word[intprio_pkg::LEVEL_W-1:0] = s_reg.cpu_level;
      default: ;
    endcase
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_next       = s_reg;
    s_next.rdata = RD_IN ? rd_word : '0;

    if (WR_IN) begin
      for (int i = 0; i < intprio_pkg::NUM_SRC; i++) begin
        if (ADDR_IN == intprio_pkg::SRC_REG[i]) begin
          s_next.prio[i] = WDATA_IN[intprio_pkg::SRC_LSB[i] +: intprio_pkg::PRIO_W];
        end
      end
      case (ADDR_IN)
        intprio_pkg::REG_INT_CONTROL_ONE: begin
          s_next.nest_dis = WDATA_IN[intprio_pkg::NEST_DIS_BIT];
          // Handler clears its trap by writing a one to the flag
          s_next.trap = s_reg.trap & ~WDATA_IN[intprio_pkg::NUM_TRAP-1:0];
        end
        intprio_pkg::REG_FLAG_STATUS: s_next.flags = s_reg.flags & ~WDATA_IN;
        intprio_pkg::REG_ENABLE_CTRL: s_next.en = WDATA_IN;
        intprio_pkg::REG_CPU_LEVEL: begin
          // Software may only move between user levels; traps own the rest
          if (s_reg.cpu_level < intprio_pkg::TRAP_LEVEL_MIN) begin
            s_next.cpu_level = {1'b0, WDATA_IN[intprio_pkg::PRIO_W-1:0]};
          end
        end
        default: ;
      endcase
    end

    // Events land after clears so a same-cycle event is never lost
    s_next.flags = s_next.flags | SRC_EVENT_IN;
    s_next.trap  = s_next.trap | TRAP_EVENT_IN;

    if (DISABLE_START_IN) begin
      s_next.dis_cnt = DISABLE_CYCLES_IN;
    end else if (s_reg.dis_cnt != '0) begin
      s_next.dis_cnt = s_reg.dis_cnt - 14'h1;
    end
    // Registered so the active flag leaves a flop with no logic behind it
    s_next.dis_act = (s_next.dis_cnt != '0);

    if (taken) begin
      // Deeper nesting than the stack holds is not saved; level still rises
      if (s_reg.depth != intprio_pkg::DEPTH_W'(intprio_pkg::STACK_DEPTH)) begin
        s_next.stack[s_reg.depth[2:0]] = s_reg.cpu_level;
        s_next.depth = s_reg.depth + 4'h1;
      end
      s_next.cpu_level = s_reg.irq.level;
    end else if (INT_RETURN_IN && (s_reg.depth != '0)) begin
      s_next.cpu_level = stack_top;
      s_next.depth     = s_reg.depth - 4'h1;
    end

    // Request is re-derived every cycle, so a flag left set is taken again
    s_next.irq = '0;
    if (!taken) begin
      if (trap_ok) begin
        s_next.irq.req   = 1'b1;
        s_next.irq.vec   = intprio_pkg::VEC_W'(trap_idx);
        s_next.irq.level = trap_level;
      end else if (user_ok) begin
        s_next.irq.req     = 1'b1;
        s_next.irq.is_user = 1'b1;
        s_next.irq.vec     = intprio_pkg::USER_VEC_BASE + intprio_pkg::VEC_W'(pick_idx);
        s_next.irq.level   = pick_level;
        s_next.irq.idx     = pick_idx;
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      s_reg <= intprio_pkg::STATE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign RDATA_OUT          = s_reg.rdata;
  assign INT_REQ_OUT        = s_reg.irq.req;
  assign INT_VECTOR_OUT     = s_reg.irq.vec;
  assign INT_LEVEL_OUT      = s_reg.irq.level;
  assign CPU_LEVEL_OUT      = s_reg.cpu_level;
  assign DISABLE_ACTIVE_OUT = s_reg.dis_act;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic user_req;
  logic en_hit;
  logic elig_hit;
  assign user_req = s_reg.irq.req && s_reg.irq.is_user;
  assign en_hit   = s_reg.en[pick_idx];
  assign elig_hit = eligible[pick_idx];

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESET_N_IN);

  sequence seq_take;
    INT_ACK_IN && INT_REQ_OUT;
  endsequence

  sequence seq_return;
    INT_RETURN_IN && !(INT_ACK_IN && INT_REQ_OUT) && (s_reg.depth != '0);
  endsequence

  zero_prio_block_a: assert property (
    user_req |-> $past(pick_prio) != intprio_pkg::PRIO_OFF && $past(elig_hit))
    else $error("request from a zero priority source");

  enable_gate_a: assert property (
    user_req |-> $past(en_hit))
    else $error("request from a disabled source");

  level_mask_a: assert property (
    user_req |-> INT_LEVEL_OUT > $past(s_reg.cpu_level))
    else $error("user request not above CPU level");

  trap_unmasked_a: assert property (
    (s_reg.trap != '0) && (trap_level > s_reg.cpu_level) && !INT_ACK_IN
    |=> INT_REQ_OUT && (INT_VECTOR_OUT < intprio_pkg::USER_VEC_BASE))
    else $error("pending trap not requested");

  timed_disable_a: assert property (
    user_req && ($past(s_reg.dis_cnt) != '0) |-> INT_LEVEL_OUT == 4'h7)
    else $error("low level request during timed disable");

  disable_load_a: assert property (
    DISABLE_START_IN |=> (s_reg.dis_cnt == $past(DISABLE_CYCLES_IN))
    && (DISABLE_ACTIVE_OUT == ($past(DISABLE_CYCLES_IN) != '0)))
    else $error("timed disable count not loaded");

  nest_block_a: assert property (
    $past(s_reg.nest_dis) && ($past(s_reg.depth) != '0) |-> !user_req)
    else $error("preemption while nesting disabled");

  take_raise_a: assert property (
    seq_take |=> (s_reg.cpu_level == $past(INT_LEVEL_OUT)) && !INT_REQ_OUT)
    else $error("taking a vector did not raise the CPU level");

  return_restore_a: assert property (
    seq_return |=> s_reg.cpu_level == $past(stack_top))
    else $error("return did not restore the stacked level");

  status_read_a: assert property (
    RD_IN && (ADDR_IN == intprio_pkg::REG_LEVEL_VECTOR)
    |=> RDATA_OUT == {4'h0, $past(s_reg.irq.level), 1'b0, $past(s_reg.irq.vec)})
    else $error("status register read mismatch");

  trap_sticky_a: assert property (
    s_reg.trap[0] && !(WR_IN && (ADDR_IN == intprio_pkg::REG_INT_CONTROL_ONE)
    && WDATA_IN[0]) |=> s_reg.trap[0])
    else $error("trap flag dropped without a clear");

  absent_src_a: assert property (
    user_req |-> $past(present[pick_idx]))
    else $error("request from an absent peripheral");

  disable_count_a: assert property (
    (s_reg.dis_cnt != '0) && !DISABLE_START_IN
    |=> s_reg.dis_cnt == $past(s_reg.dis_cnt) - 14'h1)
    else $error("timed disable count did not step down");

  top_level_pass_a: assert property (
    (s_reg.dis_cnt != '0) && pick_found && (pick_prio == intprio_pkg::PRIO_TOP)
    && (s_reg.cpu_level < 4'h7) && !s_reg.nest_dis && (s_reg.trap == '0) && !INT_ACK_IN
    |=> INT_REQ_OUT && (INT_LEVEL_OUT == 4'h7))
    else $error("level seven held off by timed disable");

  user_request_a: assert property (
    pick_found && (pick_level > s_reg.cpu_level) && (s_reg.dis_cnt == '0)
    && !(s_reg.nest_dis && (s_reg.depth != '0)) && (s_reg.trap == '0) && !INT_ACK_IN
    |=> INT_REQ_OUT && (INT_VECTOR_OUT == intprio_pkg::USER_VEC_BASE + 7'($past(pick_idx))))
    else $error("eligible source not requested");

  trap_level_a: assert property (
    INT_REQ_OUT && !s_reg.irq.is_user |-> INT_LEVEL_OUT >= intprio_pkg::TRAP_LEVEL_MIN)
    else $error("trap request below trap levels");

  level_write_a: assert property (
    WR_IN && (ADDR_IN == intprio_pkg::REG_CPU_LEVEL) && !INT_ACK_IN && !INT_RETURN_IN
    && (s_reg.cpu_level < intprio_pkg::TRAP_LEVEL_MIN)
    |=> s_reg.cpu_level == {1'b0, $past(WDATA_IN[intprio_pkg::PRIO_W-1:0])})
    else $error("CPU level write not applied");

  // ------------------------------------------------------------
  // Checks: register view
  // ------------------------------------------------------------

  unmapped_read_a: assert property (
    RD_IN && (ADDR_IN > intprio_pkg::REG_CPU_LEVEL) |=> RDATA_OUT == '0)
    else $error("unmapped address read not zero");

  slot_gap_a: assert property (
    RD_IN && (ADDR_IN <= intprio_pkg::REG_PRIO_DAC) |=> (RDATA_OUT & 16'h8888) == 16'h0000)
    else $error("priority register gap bit set");

endmodule

/* File: bench/cpu_core_model.sv */
`timescale 1ns/1ps
module cpu_core_model (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       auto_in,
  input  wire logic [7:0] hold_in,
  input  wire logic       req_in,
  output logic            ack_out,
  output logic            ret_out
);
  // ------------------------------------------------------------
  // Service timer
  // ------------------------------------------------------------
  logic [7:0] cnt_reg;

  // Only one service at a time; the bench never starts a second, nested service
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_out <= 1'b0;
      ret_out <= 1'b0;
      cnt_reg <= 8'h00;
    end else begin
      ack_out <= 1'b0;
      ret_out <= 1'b0;
      if (cnt_reg != 8'h00) begin
        cnt_reg <= cnt_reg - 8'h01;
        ret_out <= (cnt_reg == 8'h01);
      end else if (auto_in && req_in && !ack_out && !ret_out) begin
        ack_out <= 1'b1;
        cnt_reg <= hold_in;
      end
    end
  end
endmodule

/* File: bench/interrupt_priority_control_tb.sv */
`timescale 1ns/1ps
module interrupt_priority_control_tb;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam logic [3:0] a_st  = intprio_pkg::REG_LEVEL_VECTOR;
  localparam logic [3:0] a_ic  = intprio_pkg::REG_INT_CONTROL_ONE;
  localparam logic [3:0] a_flg = intprio_pkg::REG_FLAG_STATUS;
  localparam logic [3:0] a_en  = intprio_pkg::REG_ENABLE_CTRL;
  localparam logic [3:0] a_cpu = intprio_pkg::REG_CPU_LEVEL;
  localparam logic [5:0][15:0] rst_img = {16'h4400, 16'h4440, 16'h0444,
                                          16'h4440, 16'h4440, 16'h0440};
  logic        clk, rst_n, wr, rd, ack, ret, dstart, auto_on, req, dact;
  logic [3:0]  addr, trap, lvl, cpu;
  logic [15:0] wdata, rdata, src;
  logic [13:0] dcyc;
  logic [6:0]  vec;
  int          bad_count, checks_done;

  interrupt_priority_control i_interrupt_priority_control (
    .CLK_SYS_IN(clk), .RESET_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .SRC_EVENT_IN(src),
    .TRAP_EVENT_IN(trap), .INT_ACK_IN(ack), .INT_RETURN_IN(ret),
    .DISABLE_START_IN(dstart), .DISABLE_CYCLES_IN(dcyc), .INT_REQ_OUT(req),
    .INT_VECTOR_OUT(vec), .INT_LEVEL_OUT(lvl), .CPU_LEVEL_OUT(cpu),
    .DISABLE_ACTIVE_OUT(dact));

  cpu_core_model i_cpu_core_model (
    .clk_in(clk), .rst_n_in(rst_n), .auto_in(auto_on), .hold_in(8'd40),
    .req_in(req), .ack_out(ack), .ret_out(ret));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task conclude();
    if (bad_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task pend(input logic [15:0] e);
    chk({4'h0, lvl, 1'b0, vec}, e);
  endtask

  task wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask

  task rdc(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 chk(rdata & m, e);
  endtask

  task ev(input logic [15:0] s, input logic [3:0] t);
    @(posedge clk); src <= s; trap <= t;
    @(posedge clk); src <= 16'h0000; trap <= 4'h0;
  endtask

  // Waits for request, ack, return or end of timed disable
  task wsig(input int s, input int n);
    int k;
    k = 0;
    while ((s == 0 ? req : s == 1 ? ack : s == 2 ? ret : !dact) !== 1'b1 && k < n) begin
      @(posedge clk); #1 k++;
    end
    if (k >= n) begin
      bad_count++;
      $display("[ERR] %0t wait %h %h", $time, s, n);
      conclude();
    end
  endtask

  // Two edges first: a change lands in the registers, then in the request
  task quiet(input int n);
    repeat (2) @(posedge clk);
    repeat (n) begin
      @(posedge clk); #1 chk({15'h0, req}, 16'h0000);
    end
  endtask

  task serve(input logic [15:0] lv);
    @(posedge clk); auto_on <= 1'b1;
    wsig(1, 8);
    @(posedge clk); auto_on <= 1'b0;
    #1 chk({12'h0, cpu}, lv);
  endtask

  task unserve(input logic [15:0] lv);
    wsig(2, 60);
    @(posedge clk); #1 chk({12'h0, cpu}, lv);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_regs();
    pend(16'h0000);
    chk({12'h0, cpu}, 16'h0000);
    for (int r = 0; r < 6; r++) begin
      rdc(r[3:0], rst_img[r], 16'hffff);
      wreg(r[3:0], 16'hffff);
      rdc(r[3:0], rst_img[r] | (rst_img[r] >> 1) | (rst_img[r] >> 2), 16'hffff);
      wreg(r[3:0], 16'h0000);
      rdc(r[3:0], 16'h0000, 16'hffff);
      wreg(r[3:0], rst_img[r]);
    end
    wreg(a_st, 16'hffff);
    rdc(a_st, 16'h0000, 16'hffff);
    rdc(4'hb, 16'h0000, 16'hffff);
  endtask

  task t_walk();
    ev(16'h0001, 4'h0);
    quiet(4);
    wreg(a_en, 16'h0001);
    wsig(0, 6);
    pend(16'h0410);
    rdc(a_st, 16'h0010, 16'h00ff);
    serve(16'h0004);
    unserve(16'h0000);
    wsig(0, 4);
    pend(16'h0410);
    wreg(a_flg, 16'h0001);
    quiet(3);
  endtask

  task t_prio();
    wreg(a_en, 16'h0007);
    wreg(4'h0, 16'h0000);
    wreg(4'h1, 16'h3000);
    ev(16'h0007, 4'h0);
    wsig(0, 6);
    pend(16'h0312);
    wreg(4'h0, 16'h0330);
    repeat (3) @(posedge clk);
    #1 pend(16'h0310);
    wreg(a_flg, 16'h0007);
    quiet(3);
  endtask

  task t_mask();
    wreg(4'h0, 16'h0700);
    wreg(a_cpu, 16'h0007);
    ev(16'h0001, 4'h0);
    quiet(4);
    ev(16'h0000, 4'h1);
    wsig(0, 6);
    pend(16'h0800);
    serve(16'h0008);
    unserve(16'h0007);
    wsig(0, 4);
    pend(16'h0800);
    wreg(a_ic, 16'h000f);
    quiet(3);
    wreg(a_cpu, 16'h0000);
    wsig(0, 6);
    pend(16'h0710);
    wreg(a_flg, 16'h0001);
  endtask

  task t_timed_disable_instr();
    wreg(4'h0, 16'h0670);
    @(posedge clk); dstart <= 1'b1; dcyc <= 14'd60;
    @(posedge clk); dstart <= 1'b0;
    #1 chk({15'h0, dact}, 16'h0001);
    ev(16'h0001, 4'h0);
    quiet(5);
    ev(16'h0002, 4'h0);
    wsig(0, 6);
    pend(16'h0711);
    wreg(a_flg, 16'h0002);
    wsig(3, 80);
    wsig(0, 6);
    pend(16'h0610);
    wreg(a_flg, 16'h0001);
  endtask

  task t_nest();
    wreg(a_ic, 16'h8000);
    wreg(4'h0, 16'h0460);
    ev(16'h0001, 4'h0);
    wsig(0, 6);
    serve(16'h0004);
    ev(16'h0002, 4'h0);
    quiet(5);
    ev(16'h0000, 4'h2);
    wsig(0, 6);
    pend(16'h0901);
    wreg(a_ic, 16'h800f);
    unserve(16'h0000);
    wsig(0, 6);
    pend(16'h0611);
    wreg(a_flg, 16'hffff);
    wreg(a_ic, 16'h0000);
  endtask

  // ------------------------------------------------------------
  // Run
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    conclude();
  end

  initial begin
    {wr, rd, dstart, auto_on} = 4'h0;
    {addr, trap, wdata, src, dcyc} = '0;
    {bad_count, checks_done} = '0;
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_walk();
    t_prio();
    t_mask();
    t_timed_disable_instr();
    t_nest();
    conclude();
  end
endmodule
